// [dpd_pkg.sv]
// dpd_pkg: constants, state enums and carriers of the port request block
// assumes: both ports share one bus link clock from the bus control logic
package dpd_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int RING_W = 8;
  localparam int WCNT_W = 4;
  localparam int PCR_W = 8;
  localparam int PCR_SYNC_BIT = 5;
  localparam int OWN_BIT = 31;
  localparam logic [3:0] CODE_NOP = 4'h0;
  localparam logic [3:0] CODE_DATA = 4'h2;
  localparam logic [3:0] CODE_ADDR_OWN = 4'h4;
  localparam logic [3:0] CODE_ADDR_OTHER = 4'h8;
  localparam logic [3:0] CODE_ABORT = 4'he;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h4;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0;
  localparam logic [RING_W-1:0] PTR_ONE = 8'h1;
  localparam logic [RING_W-1:0] PTR_ZERO = 8'h0;
  localparam logic [WCNT_W-1:0] WCNT_ONE = 4'h1;
  localparam logic [WCNT_W-1:0] WCNT_ZERO = 4'h0;
  // request line layout: [3:2] direction, [1] descriptor type, [0] page
  localparam int REQ_PAGE = 0;
  localparam int REQ_DESC = 1;
  localparam int REQ_DIR_LSB = 2;
  localparam logic [1:0] DIR_IDLE = 2'h0;
  localparam logic [1:0] DIR_READ = 2'h1;
  localparam logic [1:0] DIR_WRITE = 2'h2;
  localparam logic [3:0] REQ_NONE = 4'h0;
  typedef enum logic [1:0] {PST_IDLE, PST_READ, PST_WRITE} dpd_pstate_t;
  typedef enum logic [1:0] {RING_READY, RING_LAST, RING_EMPTY} dpd_ring_t;
  // requests of the main controller, sys_clk domain
  typedef struct packed {
    logic rd_need;
    logic wr_need;
    logic rd_desc;
    logic wr_ind;
    logic prio_write;
    logic par_en;
    logic [RING_W-1:0] ring_max;
    logic [ADDR_W-1:0] start_addr;
  } dpd_main_t;
  typedef struct packed {
    dpd_main_t m;
    logic sync_mode;
  } dpd_need_t;
  typedef struct packed {
    logic sel0_b;
    logic sel1_b;
    logic [3:0] code;
    logic rd;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] par;
  } dpd_pin_in_t;
  typedef struct packed {
    logic ring_empty;
    logic tx_abort_ind;
    logic rx_discard;
    logic parity_error;
    logic read_valid;
  } dpd_stat_t;
  typedef struct packed {
    dpd_need_t need;
    logic ready_tgl;
  } dpd_core_t;
  typedef struct packed {
    logic rst1;
    logic rst2;
    dpd_need_t s1;
    dpd_need_t s2;
    dpd_need_t s3;
    dpd_need_t nd;
    logic t1;
    logic t2;
    logic t3;
    logic tf;
    dpd_pstate_t pst;
    dpd_ring_t ring;
    logic [RING_W-1:0] ptr;
    logic [WCNT_W-1:0] wcnt;
    logic [ADDR_W-1:0] addr;
    logic cs_prev;
    logic [3:0] req;
    logic [DATA_W-1:0] dout;
    logic oe_b;
    logic [DATA_W-1:0] rword;
    dpd_stat_t stat;
  } dpd_link_t;
endpackage

// [dpd_top.sv]
// dpd_top: request control of two 32-bit slave DMA ports
// assumes: bus logic clocks both ports on bus_link_clk, pins sync to it
// What this block does
// - own bit set advances ring pointer; clear holds pointer, ring goes Last, then Empty
// - one extra descriptor read after a non-owned entry, its data ignored
// - an Empty ring requests no descriptor reads until set Ready again
// - ring pointer steps per entry and wraps inside ring max length
// - parity checked on every byte of the whole transmit data word
// - four request lines show port state and next cycle needed
// - states Idle, Read, Write; Idle negates all requests
// - leaving Idle is synchronous or asynchronous per port mode
// - read/write switches follow priority, always on chip select
// - page bit only for same page, direction and type; off on wrap
// - request lines change on data or no-op access
// - access code sampled when chip select asserts
// - data access advances the address generator
// - address codes return own or other port address on data pins
// - code 0000 is no-op, 1110 abort; address writes reserved
// - register accesses accepted in any state
// - abort in transmit data read flags fragment in indication
// - abort in descriptor read makes ring Empty
// - abort in receive data write discards the frame
// - abort leaves indication writes and request lines alone
// - no-op drives data on a read and, in synchronous mode, leaves Idle; nothing else
// - control register bit 5 picks synchronous mode

// one port: main-controller side on sys_clk, pin side on link_clk
module dpd_port #(
  parameter int DESC_WORDS = 2,
  parameter int PAGE_LSB = 11
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic [dpd_pkg::PCR_W-1:0] port_control_register,
  input wire dpd_pkg::dpd_main_t main_req,
  input wire logic ring_set_ready,
  input wire dpd_pkg::dpd_pin_in_t pins,
  input wire logic [dpd_pkg::DATA_W-1:0] write_word,
  input wire logic [dpd_pkg::ADDR_W-1:0] other_addr,
  output logic [3:0] request_lines,
  output logic [dpd_pkg::DATA_W-1:0] data_out,
  output logic data_oe_b,
  output logic [dpd_pkg::ADDR_W-1:0] gen_addr,
  output logic [dpd_pkg::DATA_W-1:0] read_word,
  output logic [dpd_pkg::RING_W-1:0] ring_read_pointer,
  output dpd_pkg::dpd_stat_t status
);
  localparam logic [dpd_pkg::WCNT_W-1:0] WCNT_LAST =
    dpd_pkg::WCNT_W'(DESC_WORDS - 1);
  dpd_pkg::dpd_core_t c_r, c_nxt;
  dpd_pkg::dpd_link_t r, l_nxt;
  logic link_rst_b;
  logic cs_act, cs_edge, ready_evt, rd_pend, wr_pend;

  // core side: register controller requests, ready pulse becomes a toggle
  always_comb begin
    c_nxt = c_r;
    c_nxt.need.m = main_req;
    c_nxt.need.sync_mode = port_control_register[dpd_pkg::PCR_SYNC_BIT];
    if (ring_set_ready) begin
      c_nxt.ready_tgl = ~c_r.ready_tgl;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // reset leaves the link domain only on a link clock edge
  assign link_rst_b = r.rst2;
  // one select per access is the bus logic's duty, so or-ing is safe
  assign cs_act = ~pins.sel0_b | ~pins.sel1_b;
  assign cs_edge = cs_act & ~r.cs_prev;
  assign ready_evt = (r.t2 == r.t3) && (r.t3 != r.tf);
  // an empty ring stops asking for descriptors
  assign rd_pend = r.nd.m.rd_need &&
    !(r.nd.m.rd_desc && r.ring == dpd_pkg::RING_EMPTY);
  assign wr_pend = r.nd.m.wr_need;

  function automatic dpd_pkg::dpd_pstate_t pick(input logic rp,
                                                 input logic wp,
                                                 input logic pw);
    dpd_pkg::dpd_pstate_t s;
    s = dpd_pkg::PST_IDLE;
    if (rp && wp) begin
      s = pw ? dpd_pkg::PST_WRITE : dpd_pkg::PST_READ;
    end else if (rp) begin
      s = dpd_pkg::PST_READ;
    end else if (wp) begin
      s = dpd_pkg::PST_WRITE;
    end
    return s;
  endfunction

  // link side: synchronisers, port state, ring walk, pins
  always_comb begin
    logic upd;
    logic wrapped;
    logic dsc;
    upd = 1'b0;
    wrapped = 1'b0;
    dsc = 1'b0;
    l_nxt = r;
    l_nxt.rst1 = 1'b1;
    l_nxt.rst2 = r.rst1;
    // quasi-static words: a change is taken once two stages agree
    l_nxt.s1 = c_r.need;
    l_nxt.s2 = r.s1;
    l_nxt.s3 = r.s2;
    if (r.s2 == r.s3) begin
      l_nxt.nd = r.s3;
    end
    l_nxt.t1 = c_r.ready_tgl;
    l_nxt.t2 = r.t1;
    l_nxt.t3 = r.t2;
    if (r.t2 == r.t3) begin
      l_nxt.tf = r.t3;
    end
    l_nxt.cs_prev = cs_act;
    l_nxt.stat.tx_abort_ind = 1'b0;
    l_nxt.stat.rx_discard = 1'b0;
    l_nxt.stat.parity_error = 1'b0;
    l_nxt.stat.read_valid = 1'b0;
    if (ready_evt) begin
      l_nxt.ring = dpd_pkg::RING_READY;
      l_nxt.wcnt = dpd_pkg::WCNT_ZERO;
    end
    // code taken only on the assertion edge of a chip select
    if (cs_edge) begin
      unique case (pins.code)
        dpd_pkg::CODE_DATA: begin
          l_nxt.addr = r.addr + dpd_pkg::ADDR_STEP;
          if (r.pst == dpd_pkg::PST_WRITE && pins.rd) begin
            l_nxt.dout = write_word;
          end
          if (r.pst == dpd_pkg::PST_READ && r.nd.m.rd_desc) begin
            if (r.ring == dpd_pkg::RING_LAST) begin
              l_nxt.ring = dpd_pkg::RING_EMPTY;
            end else if (r.ring == dpd_pkg::RING_READY) begin
              l_nxt.rword = pins.data;
              l_nxt.stat.read_valid = 1'b1;
              if (r.wcnt == dpd_pkg::WCNT_ZERO) begin
                if (pins.data[dpd_pkg::OWN_BIT]) begin
                  // pointer wraps at the ring's max length
                  if (r.ptr + dpd_pkg::PTR_ONE >= r.nd.m.ring_max) begin
                    l_nxt.ptr = dpd_pkg::PTR_ZERO;
                    wrapped = 1'b1;
                  end else begin
                    l_nxt.ptr = r.ptr + dpd_pkg::PTR_ONE;
                  end
                end else begin
                  l_nxt.ring = dpd_pkg::RING_LAST;
                end
              end
              l_nxt.wcnt = (r.wcnt == WCNT_LAST) ? dpd_pkg::WCNT_ZERO :
                r.wcnt + dpd_pkg::WCNT_ONE;
            end
          end else if (r.pst == dpd_pkg::PST_READ) begin
            l_nxt.rword = pins.data;
            l_nxt.stat.read_valid = 1'b1;
            // whole word checked, whatever bytes are really valid
            if (r.nd.m.par_en) begin
              for (int i = 0; i < dpd_pkg::LANES; i++) begin
                if (^{pins.data[8*i +: 8], pins.par[i]} == 1'b0) begin
                  l_nxt.stat.parity_error = 1'b1;
                end
              end
            end
          end
          // direction switches only here, on a chip select edge
          if (r.pst != dpd_pkg::PST_IDLE) begin
            l_nxt.pst = pick(rd_pend && l_nxt.ring != dpd_pkg::RING_EMPTY,
                             wr_pend, r.nd.m.prio_write);
            upd = 1'b1;
          end
        end
        dpd_pkg::CODE_NOP: begin
          // no-op still answers a read on the data pins
          if (pins.rd) begin
            l_nxt.dout = r.dout;
          end
          if (r.pst == dpd_pkg::PST_IDLE && r.nd.sync_mode) begin
            l_nxt.pst = pick(rd_pend, wr_pend, r.nd.m.prio_write);
            upd = 1'b1;
          end
        end
        dpd_pkg::CODE_ADDR_OWN: begin
          // address writes are reserved and ignored
          if (pins.rd) begin
            l_nxt.dout = r.addr;
          end
        end
        dpd_pkg::CODE_ADDR_OTHER: begin
          if (pins.rd) begin
            l_nxt.dout = other_addr;
          end
        end
        dpd_pkg::CODE_ABORT: begin
          // request lines stay; one more data access ends the transfer
          if (r.pst == dpd_pkg::PST_READ && r.nd.m.rd_desc) begin
            l_nxt.ring = dpd_pkg::RING_EMPTY;
          end else if (r.pst == dpd_pkg::PST_READ) begin
            l_nxt.stat.tx_abort_ind = 1'b1;
          end else if (r.pst == dpd_pkg::PST_WRITE && !r.nd.m.wr_ind) begin
            l_nxt.stat.rx_discard = 1'b1;
          end
        end
        default: begin
          // register accesses belong elsewhere and may come at any time
          l_nxt.pst = r.pst;
        end
      endcase
    end
    // asynchronous mode leaves Idle without waiting for a select
    if (r.pst == dpd_pkg::PST_IDLE && !r.nd.sync_mode && !upd &&
        (rd_pend || wr_pend)) begin
      l_nxt.pst = pick(rd_pend, wr_pend, r.nd.m.prio_write);
      upd = 1'b1;
    end
    if (r.pst == dpd_pkg::PST_IDLE && l_nxt.pst != dpd_pkg::PST_IDLE) begin
      l_nxt.addr = r.nd.m.start_addr;
    end
    // requests move only with a data or no-op access, or an async start
    if (upd) begin
      unique case (l_nxt.pst)
        dpd_pkg::PST_IDLE: begin
          l_nxt.req = dpd_pkg::REQ_NONE;
        end
        dpd_pkg::PST_READ: begin
          dsc = r.nd.m.rd_desc;
          l_nxt.req = {dpd_pkg::DIR_READ, dsc, 1'b0};
        end
        dpd_pkg::PST_WRITE: begin
          dsc = r.nd.m.wr_ind;
          l_nxt.req = {dpd_pkg::DIR_WRITE, dsc, 1'b0};
        end
      endcase
      l_nxt.req[dpd_pkg::REQ_PAGE] = (l_nxt.pst != dpd_pkg::PST_IDLE) &&
        (l_nxt.pst == r.pst) && (dsc == r.req[dpd_pkg::REQ_DESC]) &&
        (l_nxt.addr[dpd_pkg::ADDR_W-1:PAGE_LSB] ==
         r.addr[dpd_pkg::ADDR_W-1:PAGE_LSB]) && !(dsc && wrapped);
    end
    l_nxt.stat.ring_empty = (l_nxt.ring == dpd_pkg::RING_EMPTY);
    l_nxt.oe_b = !(cs_act && pins.rd && (pins.code == dpd_pkg::CODE_NOP ||
      pins.code == dpd_pkg::CODE_DATA || pins.code == dpd_pkg::CODE_ADDR_OWN ||
      pins.code == dpd_pkg::CODE_ADDR_OTHER));
  end

  // all state clears asynchronously; only the reset stages move before the synced release
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.oe_b <= 1'b1;
      r.ring <= dpd_pkg::RING_EMPTY;
      r.stat.ring_empty <= 1'b1;
    end else if (!link_rst_b) begin
      r.rst1 <= l_nxt.rst1;
      r.rst2 <= l_nxt.rst2;
    end else begin
      r <= l_nxt;
    end
  end

  assign request_lines = r.req;
  assign data_out = r.dout;
  assign data_oe_b = r.oe_b;
  assign gen_addr = r.addr;
  assign read_word = r.rword;
  assign ring_read_pointer = r.ptr;
  assign status = r.stat;

  property p_idle_quiet;
    @(posedge link_clk) disable iff (!link_rst_b)
      r.pst == dpd_pkg::PST_IDLE |-> r.req == dpd_pkg::REQ_NONE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle port shows a request");
  property p_empty_holds;
    @(posedge link_clk) disable iff (!link_rst_b)
      r.ring == dpd_pkg::RING_EMPTY && !ready_evt |=>
        r.ring == dpd_pkg::RING_EMPTY && $stable(r.ptr);
  endproperty
  a_empty_holds: assert property (p_empty_holds)
    else $error("empty ring left without a ready");
  property p_ptr_inside;
    @(posedge link_clk) disable iff (!link_rst_b)
      $changed(r.ptr) |-> r.ptr < r.nd.m.ring_max || r.ptr == '0;
  endproperty
  a_ptr_inside: assert property (p_ptr_inside)
    else $error("ring pointer past max length");
  property p_addr_step;
    @(posedge link_clk) disable iff (!link_rst_b)
      cs_edge && pins.code == dpd_pkg::CODE_DATA &&
        r.pst != dpd_pkg::PST_IDLE |=>
        r.addr == $past(r.addr) + dpd_pkg::ADDR_STEP;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step on data access");
  property p_abort_keeps_req;
    @(posedge link_clk) disable iff (!link_rst_b)
      cs_edge && pins.code == dpd_pkg::CODE_ABORT &&
        r.pst != dpd_pkg::PST_IDLE |=> $stable(r.req);
  endproperty
  a_abort_keeps_req: assert property (p_abort_keeps_req)
    else $error("abort changed request lines");
  property p_not_owned;
    @(posedge link_clk) disable iff (!link_rst_b)
      cs_edge && pins.code == dpd_pkg::CODE_DATA &&
        r.pst == dpd_pkg::PST_READ && r.nd.m.rd_desc &&
        r.ring == dpd_pkg::RING_READY && r.wcnt == '0 &&
        !pins.data[dpd_pkg::OWN_BIT] && !ready_evt |=>
        $stable(r.ptr) ##0 r.ring == dpd_pkg::RING_LAST;
  endproperty
  a_not_owned: assert property (p_not_owned)
    else $error("not-owned entry moved the pointer");
  property p_extra_read;
    @(posedge link_clk) disable iff (!link_rst_b)
      cs_edge && pins.code == dpd_pkg::CODE_DATA && !ready_evt &&
        r.pst == dpd_pkg::PST_READ && r.nd.m.rd_desc &&
        r.ring == dpd_pkg::RING_LAST |=>
        r.ring == dpd_pkg::RING_EMPTY && !r.stat.read_valid;
  endproperty
  a_extra_read: assert property (p_extra_read)
    else $error("extra descriptor read not ignored");
  property p_own_addr;
    @(posedge link_clk) disable iff (!link_rst_b)
      cs_edge && pins.rd && pins.code == dpd_pkg::CODE_ADDR_OWN |=>
        r.dout == $past(r.addr) && !r.oe_b == $past(cs_act);
  endproperty
  a_own_addr: assert property (p_own_addr)
    else $error("address readback wrong");
  property p_sync_idle;
    @(posedge link_clk) disable iff (!link_rst_b)
      r.pst == dpd_pkg::PST_IDLE && r.nd.sync_mode &&
        !(cs_edge && pins.code == dpd_pkg::CODE_NOP) |=>
        r.pst == dpd_pkg::PST_IDLE;
  endproperty
  a_sync_idle: assert property (p_sync_idle)
    else $error("synchronous port left idle without no-op");
endmodule

// two ports on one link clock, each seeing the other's address
module dpd_top #(
  parameter int DESC_WORDS = 2,
  parameter int PAGE_LSB = 11
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bus_link_clk,
  input wire logic [dpd_pkg::PCR_W-1:0] port_a_control_register,
  input wire logic [dpd_pkg::PCR_W-1:0] port_b_control_register,
  input wire dpd_pkg::dpd_main_t port_a_main_req,
  input wire dpd_pkg::dpd_main_t port_b_main_req,
  input wire logic port_a_ring_set_ready,
  input wire logic port_b_ring_set_ready,
  input wire dpd_pkg::dpd_pin_in_t port_a_pins,
  input wire dpd_pkg::dpd_pin_in_t port_b_pins,
  input wire logic [dpd_pkg::DATA_W-1:0] port_a_write_word,
  input wire logic [dpd_pkg::DATA_W-1:0] port_b_write_word,
  output logic [3:0] port_a_request_lines,
  output logic [3:0] port_b_request_lines,
  output logic [dpd_pkg::DATA_W-1:0] port_a_data_out,
  output logic [dpd_pkg::DATA_W-1:0] port_b_data_out,
  output logic port_a_data_oe_b,
  output logic port_b_data_oe_b,
  output logic [dpd_pkg::DATA_W-1:0] port_a_read_word,
  output logic [dpd_pkg::DATA_W-1:0] port_b_read_word,
  output logic [dpd_pkg::RING_W-1:0] port_a_ring_read_pointer,
  output logic [dpd_pkg::RING_W-1:0] port_b_ring_read_pointer,
  output dpd_pkg::dpd_stat_t port_a_status,
  output dpd_pkg::dpd_stat_t port_b_status
);
  logic [dpd_pkg::ADDR_W-1:0] addr_a, addr_b;

  dpd_port #(.DESC_WORDS(DESC_WORDS), .PAGE_LSB(PAGE_LSB)) u_port_a (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(bus_link_clk),
    .port_control_register(port_a_control_register),
    .main_req(port_a_main_req), .ring_set_ready(port_a_ring_set_ready),
    .pins(port_a_pins), .write_word(port_a_write_word),
    .other_addr(addr_b), .request_lines(port_a_request_lines),
    .data_out(port_a_data_out), .data_oe_b(port_a_data_oe_b),
    .gen_addr(addr_a), .read_word(port_a_read_word),
    .ring_read_pointer(port_a_ring_read_pointer), .status(port_a_status));

  dpd_port #(.DESC_WORDS(DESC_WORDS), .PAGE_LSB(PAGE_LSB)) u_port_b (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(bus_link_clk),
    .port_control_register(port_b_control_register),
    .main_req(port_b_main_req), .ring_set_ready(port_b_ring_set_ready),
    .pins(port_b_pins), .write_word(port_b_write_word),
    .other_addr(addr_a), .request_lines(port_b_request_lines),
    .data_out(port_b_data_out), .data_oe_b(port_b_data_oe_b),
    .gen_addr(addr_b), .read_word(port_b_read_word),
    .ring_read_pointer(port_b_ring_read_pointer), .status(port_b_status));
endmodule

// [dpd_bus_model.sv]
// dpd_bus_model: bus control logic facing one port of the request block
// assumes: pins change just after a bus_link_clk edge, selects active low
module dpd_bus_model (
  input wire logic link_clk,
  output dpd_pkg::dpd_pin_in_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: both selects high, nothing selected
  initial begin
    pins = '0;
    pins.sel0_b = 1'b1;
    pins.sel1_b = 1'b1;
  end

  // test hooks: a lane mask that spoils parity, and use of the second select
  logic [3:0] par_flip = 4'h0;
  logic alt_sel = 1'b0;

  // odd parity per byte lane; par_flip breaks chosen lanes on purpose
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) odd_par[i] = ~^d[8*i +: 8];
  endfunction

  // one access: code held for the whole select, only one select used
  task automatic access(input logic [3:0] c, input logic r,
                        input logic [31:0] d, input int hold);
    @(posedge link_clk);
    if (alt_sel) begin
      pins.sel1_b <= 1'b0;
    end else begin
      pins.sel0_b <= 1'b0;
    end
    pins.code <= c;
    pins.rd <= r;
    pins.data <= d;
    pins.par <= odd_par(d) ^ par_flip;
    // a longer hold is a wait state and must still count once
    repeat (hold) @(posedge link_clk);
    pins.sel0_b <= 1'b1;
    pins.sel1_b <= 1'b1;
    // released data lines must not look like the old word
    pins.data <= ~d;
    repeat (2) @(posedge link_clk);
    #1;
  endtask
endmodule

// [testbench.sv]
// testbench: self-checking run of both ports of the request block
// assumes: one bus model per port, bus_link_clk free running at 15 ns
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SA = 32'h0000_1000;
  localparam logic [31:0] SB = 32'h0000_2000;
  logic sys_clk, bus_link_clk, rst_b, rdy_a, rdy_b;
  logic [7:0] ctl_a, ctl_b, ptr_a, ptr_b;
  dpd_pkg::dpd_main_t req_a, req_b;
  dpd_pkg::dpd_pin_in_t pin_a, pin_b;
  dpd_pkg::dpd_stat_t st_a, st_b;
  logic [31:0] wr_a, wr_b, dout_a, dout_b, rw_a, rw_b, w;
  logic [3:0] rl_a, rl_b;
  logic oe_a, oe_b;
  logic [7:0] ptr_exp [5] = '{8'h1, 8'h1, 8'h0, 8'h0, 8'h0};
  logic [31:0] exp_q [$];
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int aborts = 0;
  int perrs = 0;
  int discards = 0;

  dpd_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_link_clk(bus_link_clk),
    .port_a_control_register(ctl_a), .port_b_control_register(ctl_b),
    .port_a_main_req(req_a), .port_b_main_req(req_b),
    .port_a_ring_set_ready(rdy_a), .port_b_ring_set_ready(rdy_b),
    .port_a_pins(pin_a), .port_b_pins(pin_b),
    .port_a_write_word(wr_a), .port_b_write_word(wr_b),
    .port_a_request_lines(rl_a), .port_b_request_lines(rl_b),
    .port_a_data_out(dout_a), .port_b_data_out(dout_b),
    .port_a_data_oe_b(oe_a), .port_b_data_oe_b(oe_b),
    .port_a_read_word(rw_a), .port_b_read_word(rw_b),
    .port_a_ring_read_pointer(ptr_a), .port_b_ring_read_pointer(ptr_b),
    .port_a_status(st_a), .port_b_status(st_b));
  dpd_bus_model pa (.link_clk(bus_link_clk), .pins(pin_a));
  dpd_bus_model pb (.link_clk(bus_link_clk), .pins(pin_b));

  // clocks: 100 ns core, 15 ns link with an unrelated phase
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    bus_link_clk = 1'b0;
    #3.3;
    forever #7.5 bus_link_clk = ~bus_link_clk;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand core cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end

  // result watcher: a port a read pulse takes the oldest noted word; port b read pulses go unchecked here
  always @(posedge bus_link_clk) begin
    if (st_b.tx_abort_ind === 1'b1) aborts++;
    if (st_b.parity_error === 1'b1) perrs++;
    if (st_b.rx_discard === 1'b1) discards++;
    if (st_a.read_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected read", 32'h0, 32'hffff_ffff);
      else
        check("read word", exp_q.pop_front(), rw_a);
    end
  end

  initial begin
    void'($urandom(32'h99812a8b));
    rst_b = 1'b0;
    {rdy_a, rdy_b} = 2'h0;
    {ctl_a, ctl_b} = 16'h0;
    {req_a, req_b} = '0;
    wr_a = $urandom;
    wr_b = $urandom;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset request", 32'h0, {28'h0, rl_a});
    check("reset pointer", 32'h0, {24'h0, ptr_a});
    check("reset empty", 32'h1, {31'h0, st_a.ring_empty});
    // port a synchronous descriptor reads, port b asynchronous data reads
    ctl_a <= 8'h20;
    req_a <= '{rd_need: 1'b1, rd_desc: 1'b1, ring_max: 8'h2,
               start_addr: SA, default: '0};
    req_b <= '{rd_need: 1'b1, start_addr: SB, default: '0};
    @(posedge sys_clk);
    {rdy_a, rdy_b} <= 2'h3;
    @(posedge sys_clk);
    {rdy_a, rdy_b} <= 2'h0;
    repeat (6) @(posedge sys_clk);
    check("async leave idle", 32'h4, {28'h0, rl_b});
    check("sync waits select", 32'h0, {28'h0, rl_a});
    pa.access(dpd_pkg::CODE_NOP, 1'b0, 32'h0, 1);
    check("request after nop", 32'h6, {28'h0, rl_a});
    // two owned entries, wrap, then one not owned; odd words wait-stated
    for (int i = 0; i < 5; i++) begin
      w = $urandom;
      if (i % 2 == 0) w[31] = (i < 4);
      exp_q.push_back(w);
      pa.access(dpd_pkg::CODE_DATA, 1'b0, w, 1 + i % 2);
      check("ring pointer", {24'h0, ptr_exp[i]}, {24'h0, ptr_a});
      if (i == 0) check("same page", 32'h7, {28'h0, rl_a});
      if (i == 2) check("wrap page", 32'h6, {28'h0, rl_a});
    end
    pa.access(dpd_pkg::CODE_ADDR_OWN, 1'b1, 32'h0, 1);
    check("own address", SA + 32'h14, dout_a);
    check("bus released", 32'h1, {31'h0, oe_a});
    pa.access(dpd_pkg::CODE_ADDR_OTHER, 1'b1, 32'h0, 1);
    check("other address", SB, dout_a);
    pa.access(dpd_pkg::CODE_DATA, 1'b0, $urandom, 1);
    check("ring empty", 32'h1, {31'h0, st_a.ring_empty});
    check("idle request", 32'h0, {28'h0, rl_a});
    // register access and abort leave the request lines of port b alone
    pb.access(4'h6, 1'b0, $urandom, 1);
    check("register access", 32'h4, {28'h0, rl_b});
    pb.access(dpd_pkg::CODE_ADDR_OWN, 1'b0, 32'h0, 1);
    check("address write", 32'h4, {28'h0, rl_b});
    pb.access(dpd_pkg::CODE_ABORT, 1'b0, 32'h0, 1);
    check("abort request", 32'h4, {28'h0, rl_b});
    check("abort flag", 32'h1, aborts);
    pb.access(dpd_pkg::CODE_ADDR_OWN, 1'b1, 32'h0, 1);
    check("b address", SB, dout_b);
    // port b: both directions pending, write wins; bad parity, then discard
    @(posedge sys_clk);
    req_b <= '{rd_need: 1'b1, wr_need: 1'b1, prio_write: 1'b1,
               par_en: 1'b1, start_addr: SB, default: '0};
    repeat (4) @(posedge sys_clk);
    w = $urandom;
    pb.par_flip = 4'h2;
    pb.alt_sel = 1'b1;
    pb.access(dpd_pkg::CODE_DATA, 1'b0, w, 1);
    pb.par_flip = 4'h0;
    check("b read word", w, rw_b);
    check("b parity", 32'h1, perrs);
    check("switch to write", 32'h8, {28'h0, rl_b});
    pb.access(dpd_pkg::CODE_DATA, 1'b1, 32'h0, 2);
    check("write word", wr_b, dout_b);
    check("write page", 32'h9, {28'h0, rl_b});
    check("b released", 32'h1, {31'h0, oe_b});
    check("b pointer", 32'h0, {24'h0, ptr_b});
    pb.access(dpd_pkg::CODE_ABORT, 1'b0, 32'h0, 1);
    check("discard", 32'h1, discards);
    check("write abort request", 32'h9, {28'h0, rl_b});
    complete_run();
  end
endmodule
